// File: hw/edx_pkg.sv
package edx_pkg;
  // Register byte addresses
  localparam logic [7:0] EDX_A_CTRL = 8'h00;
  localparam logic [7:0] EDX_A_WIN  = 8'h04;
  localparam logic [7:0] EDX_A_CYC  = 8'h08;
  localparam logic [7:0] EDX_A_DIV  = 8'h0C;
  localparam logic [7:0] EDX_A_POS  = 8'h10;
  localparam logic [7:0] EDX_A_BLK  = 8'h14;
  localparam logic [7:0] EDX_A_STAT = 8'h18;
  // Control field positions, and the row field of the block register
  localparam int EDX_F_OUT = 0;
  localparam int EDX_F_IN  = 2;
  localparam int EDX_F_BST = 4;
  localparam int EDX_F_SRC = 5;
  localparam int EDX_F_CMB = 7;
  localparam int EDX_F_PAT = 9;
  localparam int EDX_F_ROW = 8;
  // Step sizes as shifts: window 128 bits, position 16 bits, per channel
  localparam int EDX_WSTEP_SH = 7;
  localparam int EDX_PSTEP_SH = 4;
  localparam logic [1:0] EDX_CMB_MAX = 2'h2;
  // Limits in single-channel bits; step counts stay the same when combined
  localparam int EDX_MIN_WIN_BITS = 12800;
  localparam int EDX_MIN_CYC_BITS = 25600;
  localparam int EDX_GAP_BITS     = 512;
  localparam logic [31:0] EDX_MIN_WIN = 32'(EDX_MIN_WIN_BITS >> EDX_WSTEP_SH);
  localparam logic [31:0] EDX_MIN_CYC = 32'(EDX_MIN_CYC_BITS >> EDX_WSTEP_SH);
  localparam logic [31:0] EDX_GAP     = 32'(EDX_GAP_BITS >> EDX_WSTEP_SH);
  localparam logic [31:0] EDX_MAX_CYC = 32'h0100_0000;
  // Divider limits
  localparam logic       EDX_NARROW_RATE = 1'b0;
  localparam logic [8:0] EDX_DIV_MIN     = 9'h008;
  localparam logic [8:0] EDX_DIV_MAX     = 9'h1FF;
  localparam logic [8:0] EDX_DIV_16      = 9'h010;
  localparam logic [8:0] EDX_DIV_32      = 9'h020;
  localparam logic [8:0] EDX_DIV_64      = 9'h040;
  localparam logic [8:0] EDX_DIV_RST     = 9'h040;
  // Reset values
  localparam logic [31:0] EDX_WIN_RST = 32'h0000_0064;
  localparam logic [31:0] EDX_CYC_RST = 32'h0000_00C8;

  typedef enum logic [1:0] {
    EDX_OUT_DIV   = 2'b00,
    EDX_OUT_PSYNC = 2'b01,
    EDX_OUT_SYNC  = 2'b10,
    EDX_OUT_ERR   = 2'b11
  } edx_out_t;
  typedef enum logic [1:0] {
    EDX_IN_BURST = 2'b00,
    EDX_IN_MASK  = 2'b01,
    EDX_IN_CAPT  = 2'b10,
    EDX_IN_OFF   = 2'b11
  } edx_in_t;
  typedef enum logic [1:0] {
    EDX_SRC_INT  = 2'b00,
    EDX_SRC_TRIG = 2'b01,
    EDX_SRC_EN   = 2'b10
  } edx_src_t;
  typedef enum logic [1:0] {
    EDX_PAT_PLAIN = 2'b00,
    EDX_PAT_MIXED = 2'b01,
    EDX_PAT_SEQ   = 2'b10
  } edx_pat_t;
endpackage

// File: hw/edx_aux_io.sv
// Added by the designer: the placing of the registers and the plain strobed port.
module edx_aux_io
  import edx_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [31:0] rdata_o,
  input  wire logic        aux_i,
  output logic             aux_out_o,
  input  wire logic        bit_vld_i,
  input  wire logic        pat_start_i,
  input  wire logic        err_i,
  input  wire logic        sync_i,
  input  wire logic [7:0]  blk_i,
  input  wire logic [7:0]  row_i,
  output logic             meas_en_o,
  output logic             capture_o
);
  edx_out_t    out_q;
  edx_in_t     in_q;
  edx_src_t    src_q;
  edx_pat_t    pat_q;
  logic        bst_q;
  logic [1:0]  cmb_q;
  logic [31:0] win_q;
  logic [31:0] cyc_q;
  logic [8:0]  div_q;
  logic [31:0] pos_q;
  logic [7:0]  blk_q;
  logic [7:0]  row_q;
  logic        aux_m_q;
  logic        aux_s_q;
  logic        aux_d_q;
  logic        rise;
  logic [9:0]  stp_q;
  logic [9:0]  stp_max;
  logic        bit_end;
  logic [31:0] gcnt_q;
  logic [31:0] win_eff;
  logic        open_q;
  logic        trig_start;
  logic        valid;
  logic        mask;
  logic [39:0] pcnt_q;
  logic [39:0] pos_bits;
  logic        pos_hit;
  logic [8:0]  dcnt_q;
  logic        psync;
  logic        aux_d;
  logic [31:0] rdata_q;
  logic        aux_out_q;
  logic        meas_en_q;
  logic        capture_q;
  logic [31:0] wclamp;
  logic [31:0] cclamp;
  logic        div_ok;

  // Write-side limits on window, cycle and divider
  always_comb begin
    wclamp = (wdata_i < EDX_MIN_WIN) ? EDX_MIN_WIN : wdata_i;
    cclamp = (wdata_i < EDX_MIN_CYC) ? EDX_MIN_CYC : wdata_i;
    if (cclamp > EDX_MAX_CYC) begin
      cclamp = EDX_MAX_CYC;
    end
    if (EDX_NARROW_RATE) begin
      div_ok = (wdata_i[8:0] == EDX_DIV_16) || (wdata_i[8:0] == EDX_DIV_32)
            || (wdata_i[8:0] == EDX_DIV_64);
    end else begin
      div_ok = (wdata_i[8:0] >= EDX_DIV_MIN) && (wdata_i[8:0] <= EDX_DIV_MAX);
    end
    div_ok = div_ok && (wdata_i[31:9] == 23'h00_0000);
  end

  // Configuration registers; out-of-range divider writes are dropped
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_q <= EDX_OUT_DIV;
      in_q  <= EDX_IN_OFF;
      src_q <= EDX_SRC_INT;
      pat_q <= EDX_PAT_PLAIN;
      bst_q <= 1'b0;
      cmb_q <= 2'h0;
      win_q <= EDX_WIN_RST;
      cyc_q <= EDX_CYC_RST;
      div_q <= EDX_DIV_RST;
      pos_q <= 32'h0000_0000;
      blk_q <= 8'h00;
      row_q <= 8'h00;
    end else if (we_i) begin
      unique case (addr_i)
        EDX_A_CTRL: begin
          out_q <= edx_out_t'(wdata_i[EDX_F_OUT +: 2]);
          in_q  <= edx_in_t'(wdata_i[EDX_F_IN +: 2]);
          bst_q <= wdata_i[EDX_F_BST];
          if (wdata_i[EDX_F_SRC +: 2] != 2'b11) begin
            src_q <= edx_src_t'(wdata_i[EDX_F_SRC +: 2]);
          end
          cmb_q <= (wdata_i[EDX_F_CMB +: 2] > EDX_CMB_MAX) ? EDX_CMB_MAX
                 : wdata_i[EDX_F_CMB +: 2];
          if (wdata_i[EDX_F_PAT +: 2] != 2'b11) begin
            pat_q <= edx_pat_t'(wdata_i[EDX_F_PAT +: 2]);
          end
        end
        EDX_A_WIN: win_q <= wclamp;
        EDX_A_CYC: cyc_q <= cclamp;
        EDX_A_DIV: begin
          if (div_ok) begin
            div_q <= wdata_i[8:0];
          end
        end
        EDX_A_POS: pos_q <= wdata_i;
        EDX_A_BLK: begin
          blk_q <= wdata_i[7:0];
          row_q <= wdata_i[EDX_F_ROW +: 8];
        end
        default: ;
      endcase
    end
  end

  // Aux pin resynchroniser; the second stage feeds logic, the third only the rise detect
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aux_m_q <= 1'b0;
      aux_s_q <= 1'b0;
      aux_d_q <= 1'b0;
    end else begin
      aux_m_q <= aux_i;
      aux_s_q <= aux_m_q;
      aux_d_q <= aux_s_q;
    end
  end
  assign rise = aux_s_q && !aux_d_q;

  // Window step is 128 bits per channel combined
  assign stp_max = 10'((32'd1 << (EDX_WSTEP_SH + int'(cmb_q))) - 32'd1);
  // Greater-or-equal: a step count left above a smaller limit after a
  // combination change ends its step at once instead of wrapping 10 bits
  assign bit_end = bit_vld_i && (stp_q >= stp_max);
  assign trig_start = bst_q && (in_q == EDX_IN_BURST) && (src_q == EDX_SRC_TRIG)
                   && rise && !open_q;
  // Window is cut short so the idle gap before cycle end always remains
  assign win_eff = (win_q < cyc_q - EDX_GAP) ? win_q : cyc_q - EDX_GAP;

  // Bit counter inside one step; a trigger realigns it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stp_q <= 10'h000;
    end else if (trig_start) begin
      stp_q <= 10'h000;
    end else if (bit_vld_i) begin
      stp_q <= bit_end ? 10'h000 : stp_q + 10'h001;
    end
  end

  // Step counter: free cycle for the internal gate, window length for trigger
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gcnt_q <= 32'h0000_0000;
      open_q <= 1'b0;
    end else if (src_q == EDX_SRC_TRIG) begin
      if (trig_start) begin
        gcnt_q <= 32'h0000_0000;
        open_q <= 1'b1;
      end else if (open_q && bit_end) begin
        gcnt_q <= gcnt_q + 32'h0000_0001;
        if (gcnt_q >= win_q - 32'h0000_0001) begin
          open_q <= 1'b0;
        end
      end
    end else begin
      open_q <= 1'b0;
      if (bit_end) begin
        gcnt_q <= (gcnt_q >= cyc_q - 32'h0000_0001) ? 32'h0000_0000
                : gcnt_q + 32'h0000_0001;
      end
    end
  end

  // Gate and mask decision for each received bit
  always_comb begin
    valid = 1'b1;
    if (bst_q) begin
      unique case (src_q)
        EDX_SRC_INT:  valid = gcnt_q < win_eff;
        EDX_SRC_TRIG: valid = open_q;
        EDX_SRC_EN:   valid = aux_s_q && (in_q == EDX_IN_BURST);
        default:      valid = 1'b0;
      endcase
    end
    mask = (in_q == EDX_IN_MASK) && !aux_s_q;
  end

  // Qualified bit strobe to the counters, and capture start pulse
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meas_en_q <= 1'b0;
      capture_q <= 1'b0;
    end else begin
      meas_en_q <= bit_vld_i && valid && !mask;
      capture_q <= (in_q == EDX_IN_CAPT) && rise;
    end
  end

  // Bit position since pattern start, in 16-bit steps per channel
  assign pos_bits = {8'h00, pos_q} << (EDX_PSTEP_SH + int'(cmb_q));
  assign pos_hit  = bit_vld_i && (pcnt_q == pos_bits);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pcnt_q <= 40'h00_0000_0000;
    end else if (pat_start_i) begin
      pcnt_q <= {39'h0, bit_vld_i};
    end else if (bit_vld_i) begin
      pcnt_q <= pcnt_q + 40'h00_0000_0001;
    end
  end

  // Divider restarts on every pattern start to keep its phase locked
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dcnt_q <= 9'h000;
    end else if (pat_start_i) begin
      dcnt_q <= 9'h000;
    end else if (bit_vld_i) begin
      dcnt_q <= (dcnt_q >= div_q - 9'h001) ? 9'h000 : dcnt_q + 9'h001;
    end
  end

  // Sync pulse source per pattern type
  always_comb begin
    unique case (pat_q)
      EDX_PAT_PLAIN: psync = pos_hit;
      EDX_PAT_MIXED: psync = (blk_i == blk_q) && (row_i == row_q);
      EDX_PAT_SEQ:   psync = pos_hit && (blk_i == blk_q);
      default:       psync = 1'b0;
    endcase
  end

  // One function at a time on the aux output
  always_comb begin
    unique case (out_q)
      EDX_OUT_DIV:   aux_d = dcnt_q < (div_q >> 1);
      EDX_OUT_PSYNC: aux_d = psync;
      EDX_OUT_SYNC:  aux_d = sync_i;
      EDX_OUT_ERR:   aux_d = !err_i;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aux_out_q <= 1'b1;
    end else begin
      aux_out_q <= aux_d;
    end
  end

  // Read port; unmapped addresses read zero, data valid one cycle later
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (re_i) begin
      unique case (addr_i)
        EDX_A_CTRL: rdata_q <= {21'h0, pat_q, cmb_q, src_q, bst_q, in_q, out_q};
        EDX_A_WIN:  rdata_q <= win_q;
        EDX_A_CYC:  rdata_q <= cyc_q;
        EDX_A_DIV:  rdata_q <= {23'h0, div_q};
        EDX_A_POS:  rdata_q <= pos_q;
        EDX_A_BLK:  rdata_q <= {16'h0, row_q, blk_q};
        EDX_A_STAT: rdata_q <= {27'h0, sync_i, aux_out_q, aux_s_q, open_q, valid};
        default:    rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign rdata_o   = rdata_q;
  assign aux_out_o = aux_out_q;
  assign meas_en_o = meas_en_q;
  assign capture_o = capture_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_trig_rise;
    trig_start;
  endsequence
  sequence s_capt_pulse;
    capture_o ##1 !capture_o;
  endsequence

  property p_win_limits;
    win_q >= EDX_MIN_WIN && cyc_q >= EDX_MIN_CYC && cyc_q <= EDX_MAX_CYC;
  endproperty
  a_win_limits: assert property (p_win_limits) else $error("window limits");
  property p_gap;
    (bst_q && src_q == EDX_SRC_INT && gcnt_q >= cyc_q - EDX_GAP) |=> !meas_en_o;
  endproperty
  a_gap: assert property (p_gap) else $error("idle gap lost");
  property p_div_legal;
    div_q >= EDX_DIV_MIN && div_q <= EDX_DIV_MAX;
  endproperty
  a_div_legal: assert property (p_div_legal) else $error("divider out of range");
  property p_err_out;
    (out_q == EDX_OUT_ERR && $stable(out_q)) |=> (aux_out_o == !$past(err_i));
  endproperty
  a_err_out: assert property (p_err_out) else $error("error level wrong");
  property p_sync_out;
    (out_q == EDX_OUT_SYNC && sync_i) |=> aux_out_o;
  endproperty
  a_sync_out: assert property (p_sync_out) else $error("sync level wrong");
  property p_trig_open;
    s_trig_rise |=> open_q && gcnt_q == 32'h0000_0000;
  endproperty
  a_trig_open: assert property (p_trig_open) else $error("window not opened");
  property p_level;
    (bst_q && src_q == EDX_SRC_EN && in_q == EDX_IN_BURST && bit_vld_i && aux_s_q)
      |=> meas_en_o;
  endproperty
  a_level: assert property (p_level) else $error("enable level ignored");
  property p_mask;
    (in_q == EDX_IN_MASK && !aux_s_q) |=> !meas_en_o;
  endproperty
  a_mask: assert property (p_mask) else $error("masked bit counted");
  property p_capt;
    (in_q == EDX_IN_CAPT && $rose(aux_s_q)) |=> s_capt_pulse;
  endproperty
  a_capt: assert property (p_capt) else $error("capture pulse wrong");
  property p_no_bit;
    !bit_vld_i |=> !meas_en_o;
  endproperty
  a_no_bit: assert property (p_no_bit) else $error("strobe without bit");
  property p_psync;
    (out_q == EDX_OUT_PSYNC && pat_q == EDX_PAT_PLAIN && pos_hit) |=> aux_out_o;
  endproperty
  a_psync: assert property (p_psync) else $error("sync pulse missing");
endmodule

// File: tb/edx_far_end.sv
module edx_far_end
  import edx_pkg::*;
#(
  parameter int PLEN = 520
) (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  output logic            bit_vld_o,
  output logic            pat_start_o,
  output logic            err_o,
  output logic            sync_o,
  output logic [7:0]      blk_o,
  output logic [7:0]      row_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] bit_q;
  logic [7:0]  tick_q;

  // One bit per cycle; pattern kept above 512 bits so no combination needs repeats
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_q  <= '0;
      tick_q <= '0;
      blk_o  <= '0;
    end else begin
      tick_q <= tick_q + 8'h01;
      bit_q  <= (bit_q == 16'(PLEN - 1)) ? '0 : bit_q + 16'h0001;
      if (bit_q == 16'(PLEN - 1)) begin
        blk_o <= (blk_o + 8'h01) & 8'h03;
      end
    end
  end

  // Checker-side status; errors and sync flips come often so short runs see both
  assign bit_vld_o   = 1'b1;
  assign pat_start_o = (bit_q == 16'h0000);
  assign row_o       = {5'h00, bit_q[8:6]};
  assign err_o       = (tick_q[4:0] == 5'h11);
  assign sync_o      = tick_q[7];
endmodule

// File: tb/edx_aux_io_tb.sv
module edx_aux_io_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import edx_pkg::*;
  localparam int PLEN = 520;
  localparam logic [7:0] TA [17] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h0C,
    8'h0C, 8'h0C, 8'h0C, 8'h04, 8'h04, 8'h08, 8'h08, 8'h1C, 8'h00};
  localparam logic [31:0] TW [17] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h7,
    32'h200, 32'h1FF, 32'h8, 32'h63, 32'h12C, 32'hA, 32'h0100_0001, 32'hFFFF_FFFF, 32'h180};
  localparam logic [31:0] TX [17] = '{32'hC, 32'h64, 32'hC8, 32'h40, 32'h0, 32'h0, 32'h0,
    32'h40, 32'h40, 32'h1FF, 32'h8, 32'h64, 32'h12C, 32'hC8, 32'h0100_0000, 32'h0, 32'h100};
  localparam logic [16:0] TE = 17'h1_FF80;
  logic        clk;
  logic        arst_n;
  logic        we;
  logic        re;
  logic        aux;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        aux_out;
  logic        meas_en;
  logic        capture;
  logic        bit_vld;
  logic        pat_start;
  logic        err;
  logic        sync;
  logic [7:0]  blk;
  logic [7:0]  row;
  int          fails;
  int          cmp_count;

  edx_aux_io dut_u (.clk_i(clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
    .we_i(we), .re_i(re), .rdata_o(rdata), .aux_i(aux), .aux_out_o(aux_out),
    .bit_vld_i(bit_vld), .pat_start_i(pat_start), .err_i(err), .sync_i(sync),
    .blk_i(blk), .row_i(row), .meas_en_o(meas_en), .capture_o(capture));
  edx_far_end #(.PLEN(PLEN)) far_u (.clk_i(clk), .arst_n_i(arst_n), .bit_vld_o(bit_vld),
    .pat_start_o(pat_start), .err_o(err), .sync_o(sync), .blk_o(blk), .row_o(row));

  // Free-running bench clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  function automatic logic [31:0] ctrl(input int o, input int i, input int b, input int s,
                                       input int c, input int p);
    return 32'(o | (i << 2) | (b << 4) | (s << 5) | (c << 7) | (p << 9));
  endfunction
  task automatic wait_pat();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pat_start !== 1'b1 && n < 2 * PLEN);
    check("pat_start", pat_start, 1);
  endtask

  // Reset values, then refused and clamped writes, unmapped place included
  task automatic t_regs();
    logic [31:0] d;
    for (int k = 0; k < 17; k++) begin
      if (TE[k]) begin
        wr(TA[k], TW[k]);
      end
      rd(TA[k], d);
      check("reg", d, TX[k]);
    end
  endtask
  // Divided clock restarts at pattern start, then holds N/2 high per period
  task automatic t_div(input int n);
    int hi;
    hi = 0;
    wr(EDX_A_DIV, 32'(n));
    wr(EDX_A_CTRL, ctrl(0, 3, 0, 0, 0, 0));
    wait_pat();
    cyc(2);
    check("div_phase", aux_out, 1);
    repeat (4 * n) begin
      @(negedge clk);
      hi += (aux_out === 1'b1);
    end
    check("div_high", hi, 2 * n);
  endtask
  // One sync pulse per pattern, position scaled by channel combination
  task automatic t_psync(input int c);
    int first;
    int hi;
    first = 0;
    hi = 0;
    wr(EDX_A_POS, 32'h0000_0002);
    wr(EDX_A_CTRL, ctrl(1, 3, 0, 0, c, 0));
    wait_pat();
    for (int i = 1; i <= PLEN; i++) begin
      @(negedge clk);
      if (aux_out === 1'b1 && first == 0) first = i;
      hi += (aux_out === 1'b1);
    end
    check("psync_pos", first, 2 * (16 << c) + 1);
    check("psync_count", hi, 1);
  endtask
  // Sync level and inverted error level, one cycle behind their cause
  task automatic t_level();
    logic prev;
    for (int m = 2; m < 4; m++) begin
      wr(EDX_A_CTRL, ctrl(m, 3, 0, 0, 0, 0));
      @(negedge clk);
      repeat (300) begin
        prev = (m == 2) ? sync : !err;
        @(negedge clk);
        check("aux_level", aux_out, prev);
      end
    end
  endtask
  // Mixed follows block and row match; sequence stays quiet outside its block
  task automatic t_blk(input int p);
    logic hit;
    logic exp;
    int   n;
    n = 0;
    wr(EDX_A_BLK, 32'h0000_0301);
    wr(EDX_A_CTRL, ctrl(1, 3, 0, 0, 0, p));
    @(negedge clk);
    repeat (4 * PLEN) begin
      hit = (blk == 8'h01);
      exp = hit && (row == 8'h03);
      @(negedge clk);
      n += (aux_out === 1'b1);
      if (p == 1) check("mixed", aux_out, exp);
      else if (!hit) check("seq_blk", aux_out, 0);
    end
    // One full block rotation holds exactly one hit inside the chosen block
    if (p == 2) check("seq_count", n, 1);
  endtask
  task automatic t_mask();
    int          hi;
    logic [31:0] d;
    hi = 0;
    wr(EDX_A_CTRL, ctrl(2, 1, 0, 0, 0, 0));
    aux <= 1'b1;
    cyc(5);
    check("mask_open", meas_en, 1);
    rd(EDX_A_STAT, d);
    check("stat_open", d & 32'h0000_0007, 32'h0000_0005);
    @(posedge clk);
    aux <= 1'b0;
    cyc(4);
    repeat (16) begin
      @(negedge clk);
      hi += (meas_en === 1'b1);
    end
    check("mask_shut", hi, 0);
  endtask
  // Drives the external gate and counts qualified bits; gate used only with
  // burst and an external source
  task automatic run(input int n, input int r0, input int r1, input int r2, input int r3,
                     output int hi);
    hi = 0;
    @(posedge clk);
    aux <= 1'b0;
    cyc(4);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      aux <= (i >= r0 && i < r1) || (i >= r2 && i < r3);
      @(negedge clk);
      hi += (meas_en === 1'b1);
    end
  endtask
  task automatic t_capt();
    int hi;
    wr(EDX_A_CTRL, ctrl(2, 2, 0, 0, 0, 0));
    hi = 0;
    @(posedge clk);
    aux <= 1'b0;
    cyc(5);
    for (int i = 0; i < 30; i++) begin
      @(posedge clk);
      aux <= (i >= 2 && i < 12);
      @(negedge clk);
      hi += (capture === 1'b1);
    end
    check("capture", hi, 1);
  endtask
  // Enable level, trigger window with a refused retrigger, internal window
  // Automatic delay alignment is never chosen, so sync control stays as is
  // and window or cycle rewrites need no alignment rerun
  task automatic t_gate();
    int          hi;
    logic [31:0] d;
    wr(EDX_A_CTRL, ctrl(0, 0, 1, 2, 0, 0));
    run(80, 0, 50, 0, 0, hi);
    check("enable", hi, 50);
    wr(EDX_A_WIN, 32'h0000_0064);
    wr(EDX_A_CTRL, ctrl(0, 0, 1, 1, 1, 0));
    run(25800, 2, 5, 1000, 1003, hi);
    check("trigger", hi, 100 * 256);
    rd(EDX_A_STAT, d);
    check("stat_shut", d & 32'h0000_0007, 32'h0000_0000);
    wr(EDX_A_WIN, 32'h0000_00C7);
    wr(EDX_A_CYC, 32'h0000_00C8);
    wr(EDX_A_CTRL, ctrl(0, 0, 1, 0, 0, 0));
    cyc(10);
    run(25600, 0, 0, 0, 0, hi);
    check("internal", hi, (200 - 4) * 128);
  endtask

  initial begin
    arst_n    = 1'b0;
    addr      = '0;
    wdata     = '0;
    we        = 1'b0;
    re        = 1'b0;
    aux       = 1'b0;
    fails     = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_div(8);
    t_div(64);
    for (int c = 0; c < 3; c++) begin
      t_psync(c);
    end
    t_level();
    t_blk(1);
    t_blk(2);
    t_mask();
    t_capt();
    t_gate();
    wrap_up();
  end

  // Watchdog well past the expected run of about 61,000 cycles
  initial begin
    #(8 * 90000);
    fails++;
    wrap_up();
  end
endmodule
